// File: hdl/swc_top.sv
// sleep entry and wake-up control with an AXI4-Lite register port
//
// The AXI4-Lite slave port and the register offsets were left to the implementer.
module swc_top (
  input wire logic MCLK,
  input wire logic SRST,
  // register bus
  input wire logic [swc_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [swc_pkg::DATA_W-1:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [swc_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [swc_pkg::DATA_W-1:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // interrupt sources
  input wire logic [swc_pkg::SRC_W-1:0] INT_FLAGS,
  input wire logic [swc_pkg::SRC_W-1:0] INT_ENABLES,
  input wire logic GLOBAL_INTERRUPT_ENABLE,
  // execution core
  input wire logic HALT_EXEC,
  output logic HALT_NOP,
  output logic SLEEPING,
  output logic WAKE,
  output logic WDT_CLEAR,
  output logic EXEC_PREFETCH,
  output logic FORCE_NOP,
  output logic VECTOR_BRANCH,
  output logic IRQ
);

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  swc_pkg::swc_state_t state_q;
  logic pending;
  logic halt_take;
  logic wake_now;
  logic halt_nop_q;
  logic wake_q;
  logic wdt_clr_q;
  logic [1:0] nop_cnt_q;
  logic to_q;
  logic pd_q;
  logic wdt_en_q;
  logic [swc_pkg::EVT_W-1:0] int_stat_q;
  logic [swc_pkg::EVT_W-1:0] int_mask_q;
  logic [swc_pkg::EVT_W-1:0] int_stat_d;
  swc_pkg::swc_evt_t evt;
  swc_pkg::swc_stat_t stat;
  logic [swc_pkg::WDT_W-1:0] wdt_count;
  logic wdt_ovf;
  logic aw_held_q;
  logic w_held_q;
  logic [swc_pkg::ADDR_W-1:0] awaddr_q;
  logic [swc_pkg::DATA_W-1:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [swc_pkg::DATA_W-1:0] rdata_q;
  logic wr_go;
  logic wr_lane0;
  logic pd_rearm;

  // true when the offset names a register
  function automatic logic is_mapped(input logic [swc_pkg::ADDR_W-1:0] a);
    return (a == swc_pkg::OFS_CTRL) || (a == swc_pkg::OFS_STATUS) ||
      (a == swc_pkg::OFS_INT_STAT) || (a == swc_pkg::OFS_INT_MASK) ||
      (a == swc_pkg::OFS_WDT_COUNT);
  endfunction

  // ------------------------------------------------------------
  // halt and wake sequencing
  // ------------------------------------------------------------
  // per-source qualify
  assign pending = |(INT_FLAGS & INT_ENABLES);
  assign halt_take = HALT_EXEC && (state_q == swc_pkg::ST_RUN);
  assign wake_now = (state_q == swc_pkg::ST_SLEEP) && pending;

  // sequence state
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      state_q <= swc_pkg::ST_RUN;
    end else begin
      case (state_q)
        swc_pkg::ST_RUN: begin
          if (halt_take && !pending) begin
            state_q <= swc_pkg::ST_SLEEP;
          end
        end
        swc_pkg::ST_SLEEP: begin
          if (pending) begin
            state_q <= GLOBAL_INTERRUPT_ENABLE ? swc_pkg::ST_PREFETCH : swc_pkg::ST_RUN;
          end
        end
        swc_pkg::ST_PREFETCH: begin
          state_q <= swc_pkg::ST_FNOP;
        end
        swc_pkg::ST_FNOP: begin
          if (nop_cnt_q == swc_pkg::FORCED_NOP_CYCLES - 2'h1) begin
            state_q <= swc_pkg::ST_VECTOR;
          end
        end
        swc_pkg::ST_VECTOR: begin
          state_q <= swc_pkg::ST_RUN;
        end
        default: begin
          state_q <= swc_pkg::ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST || state_q != swc_pkg::ST_FNOP) begin
      nop_cnt_q <= 2'h0;
    end else begin
      nop_cnt_q <= nop_cnt_q + 2'h1;
    end
  end

  // one-cycle pulses to the core
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      halt_nop_q <= 1'b0;
      wake_q <= 1'b0;
      wdt_clr_q <= 1'b0;
    end else begin
      halt_nop_q <= halt_take && pending;
      wake_q <= wake_now;
      wdt_clr_q <= wake_now;
    end
  end

  // status flags
  // no change on no-op
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      to_q <= swc_pkg::RST_TIMEOUT_FLAG;
      pd_q <= swc_pkg::RST_POWER_DOWN_FLAG;
    end else begin
      if (wake_now) begin
        to_q <= 1'b1;
        pd_q <= 1'b0;
      end else begin
        if (wdt_ovf) begin
          to_q <= 1'b0;
        end
        if (pd_rearm) begin
          pd_q <= 1'b1;
        end
      end
    end
  end

  assign HALT_NOP = halt_nop_q;
  assign WAKE = wake_q;
  assign WDT_CLEAR = wdt_clr_q;
  assign SLEEPING = (state_q == swc_pkg::ST_SLEEP);
  assign EXEC_PREFETCH = (state_q == swc_pkg::ST_PREFETCH);
  assign FORCE_NOP = (state_q == swc_pkg::ST_FNOP);
  assign VECTOR_BRANCH = (state_q == swc_pkg::ST_VECTOR);

  // ------------------------------------------------------------
  // watchdog
  // ------------------------------------------------------------
  swc_wdt swc_wdt_inst (
    .clk(MCLK),
    .rst(SRST),
    .enable(wdt_en_q),
    .clear(wdt_clr_q),
    .count_q(wdt_count),
    .overflow_q(wdt_ovf)
  );

  // ------------------------------------------------------------
  // events and interrupt
  // ------------------------------------------------------------
  assign evt = '{wdt_overflow: wdt_ovf, wake: wake_q, halt_nop: halt_nop_q};
  assign stat = '{sleeping: SLEEPING, power_down_flag: pd_q, watchdog_timeout_flag: to_q};

  // write one clears, a new event wins
  always_comb begin
    int_stat_d = int_stat_q;
    if (wr_lane0 && awaddr_q == swc_pkg::OFS_INT_STAT) begin
      int_stat_d = int_stat_q & ~wdata_q[swc_pkg::EVT_W-1:0];
    end
    int_stat_d = int_stat_d | evt;
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      int_stat_q <= '0;
    end else begin
      int_stat_q <= int_stat_d;
    end
  end

  assign IRQ = |(int_stat_q & int_mask_q);

  // ------------------------------------------------------------
  // AXI4-Lite write channel
  // ------------------------------------------------------------
  assign S_AXI_AWREADY = !aw_held_q && !bvalid_q;
  assign S_AXI_WREADY = !w_held_q && !bvalid_q;
  assign wr_go = aw_held_q && w_held_q && !bvalid_q;
  assign wr_lane0 = wr_go && wstrb_q[0] && is_mapped(awaddr_q);
  assign pd_rearm = wr_lane0 && (awaddr_q == swc_pkg::OFS_CTRL) &&
    wdata_q[swc_pkg::CTRL_PD_REARM_BIT];

  // address and data capture, either order
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= 4'h0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held_q <= 1'b1;
        awaddr_q <= S_AXI_AWADDR;
      end else if (wr_go) begin
        aw_held_q <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held_q <= 1'b1;
        wdata_q <= S_AXI_WDATA;
        wstrb_q <= S_AXI_WSTRB;
      end else if (wr_go) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      bvalid_q <= 1'b0;
      bresp_q <= swc_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= is_mapped(awaddr_q) ? swc_pkg::RESP_OKAY : swc_pkg::RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid_q <= 1'b0;
    end
  end

  // control and mask registers
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      wdt_en_q <= swc_pkg::RST_WDT_EN;
      int_mask_q <= swc_pkg::RST_INT_MASK;
    end else if (wr_lane0) begin
      if (awaddr_q == swc_pkg::OFS_CTRL) begin
        wdt_en_q <= wdata_q[swc_pkg::CTRL_WDT_EN_BIT];
      end
      if (awaddr_q == swc_pkg::OFS_INT_MASK) begin
        int_mask_q <= wdata_q[swc_pkg::EVT_W-1:0];
      end
    end
  end

  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;

  // ------------------------------------------------------------
  // AXI4-Lite read channel
  // ------------------------------------------------------------
  assign S_AXI_ARREADY = !rvalid_q;

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      rvalid_q <= 1'b0;
      rresp_q <= swc_pkg::RESP_OKAY;
      rdata_q <= '0;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_q <= 1'b1;
      rresp_q <= swc_pkg::RESP_OKAY;
      rdata_q <= '0;
      case (S_AXI_ARADDR)
        swc_pkg::OFS_CTRL: rdata_q[swc_pkg::CTRL_WDT_EN_BIT] <= wdt_en_q;
        swc_pkg::OFS_STATUS: rdata_q[2:0] <= stat;
        swc_pkg::OFS_INT_STAT: rdata_q[swc_pkg::EVT_W-1:0] <= int_stat_q;
        swc_pkg::OFS_INT_MASK: rdata_q[swc_pkg::EVT_W-1:0] <= int_mask_q;
        swc_pkg::OFS_WDT_COUNT: rdata_q[swc_pkg::WDT_W-1:0] <= wdt_count;
        default: rresp_q <= swc_pkg::RESP_SLVERR;
      endcase
    end else if (S_AXI_RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RRESP = rresp_q;
  assign S_AXI_RDATA = rdata_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SRST);

  AST_PENDING_HALT_NOP: assert property (
    halt_take && pending |=> HALT_NOP && !SLEEPING && !WDT_CLEAR)
    else $error("pending halt did not run as a no-op");

  AST_NOP_KEEPS_FLAGS: assert property (
    halt_take && pending && !wdt_ovf && !pd_rearm |=> $stable(to_q) && $stable(pd_q))
    else $error("suppressed halt changed status flags");

  AST_HALT_SLEEPS: assert property (
    halt_take && !pending |=> SLEEPING)
    else $error("halt did not enter sleep");

  AST_WAKE_AT_ONCE: assert property (
    SLEEPING && pending |=> !SLEEPING && WAKE)
    else $error("sleep not left on pending interrupt");

  AST_WAKE_CLEARS_WDT: assert property (
    wake_now |=> WDT_CLEAR ##1 (wdt_count == '0))
    else $error("watchdog not cleared on wake");

  AST_WAKE_FLAGS: assert property (
    wake_now |=> to_q && !pd_q)
    else $error("wake flags wrong");

  AST_GIE_IGNORED: assert property (
    SLEEPING && pending && !GLOBAL_INTERRUPT_ENABLE |=> WAKE && !EXEC_PREFETCH ##1 !FORCE_NOP)
    else $error("wake with global enable clear misbehaved");

  AST_VECTOR_ORDER: assert property (
    wake_now && GLOBAL_INTERRUPT_ENABLE |=> EXEC_PREFETCH ##1 FORCE_NOP [*2] ##1 VECTOR_BRANCH)
    else $error("wake sequence order wrong");

  AST_IRQ_LEVEL: assert property (
    (IRQ || !(|($past(evt) & int_mask_q))) && (int_stat_q[1] || !$past(wake_q)))
    else $error("interrupt level wrong");

  COV_NOP: cover property (halt_take && pending);
  COV_SLEEP_WAKE: cover property (SLEEPING ##[1:50] WAKE);
  COV_VECTOR: cover property (EXEC_PREFETCH ##3 VECTOR_BRANCH);
  COV_WDT_OVF: cover property (wdt_ovf);

endmodule

// File: hdl/swc_wdt.sv
// watchdog counter with its prescaler; clear resets both
module swc_wdt (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic clear,
  output logic [swc_pkg::WDT_W-1:0] count_q,
  output logic overflow_q
);

  logic [swc_pkg::PRESC_W-1:0] presc_q;
  logic tick;

  assign tick = enable && (presc_q == {swc_pkg::PRESC_W{1'b1}});

  // prescaler
  always_ff @(posedge clk) begin
    if (rst || clear) begin
      presc_q <= '0;
    end else if (enable) begin
      presc_q <= presc_q + 1'b1;
    end
  end

  // counter and overflow pulse
  always_ff @(posedge clk) begin
    if (rst || clear) begin
      count_q <= '0;
      overflow_q <= 1'b0;
    end else begin
      overflow_q <= tick && (count_q == {swc_pkg::WDT_W{1'b1}});
      if (tick) begin
        count_q <= count_q + 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_WDT_CLEAR_ZERO: assert property (clear |=> (count_q == '0) && !overflow_q)
    else $error("watchdog not zero after clear");

endmodule

// File: pkg/swc_pkg.sv
// Summary of operation
// - a halt request that meets an already pending enabled interrupt runs as a no-op and leaves the watchdog alone.
// - a suppressed halt leaves the timeout flag and the power-down flag unchanged.
// - an enabled interrupt that turns up during or after the halt lets the halt complete and wakes at once.
// - a completed halt that wakes on an interrupt clears the watchdog counter and its prescaler.
// - a completed halt that wakes on an interrupt sets the timeout flag and clears the power-down flag.
// - any source with both its enable and its flag set qualifies, whatever the global interrupt enable says.
package swc_pkg;

  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SRC_W = 8;
  localparam int WDT_W = 8;
  localparam int PRESC_W = 5;

  // ------------------------------------------------------------
  // register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_INT_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_INT_MASK = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_WDT_COUNT = 8'h10;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CTRL_WDT_EN_BIT = 0;
  localparam int CTRL_PD_REARM_BIT = 1;
  localparam int EVT_W = 3;

  // ------------------------------------------------------------
  // reset values and timing counts
  // ------------------------------------------------------------
  localparam logic RST_WDT_EN = 1'b0;
  localparam logic RST_TIMEOUT_FLAG = 1'b1;
  localparam logic RST_POWER_DOWN_FLAG = 1'b1;
  localparam logic [EVT_W-1:0] RST_INT_MASK = 3'h0;
  localparam logic [1:0] FORCED_NOP_CYCLES = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RUN,
    ST_SLEEP,
    ST_PREFETCH,
    ST_FNOP,
    ST_VECTOR
  } swc_state_t;

  // status register layout, bit 2 downward
  typedef struct packed {
    logic sleeping;
    logic power_down_flag;
    logic watchdog_timeout_flag;
  } swc_stat_t;

  // interrupt event layout, bit 2 downward
  typedef struct packed {
    logic wdt_overflow;
    logic wake;
    logic halt_nop;
  } swc_evt_t;

endpackage

// File: sim/swc_core_model.sv
// execution core and interrupt sources seen from the block
module swc_core_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic halt_go,
  input wire logic [7:0] src_flags,
  input wire logic [7:0] src_en,
  input wire logic global_interrupt_enable,
  input wire logic sleeping,
  output logic halt_exec,
  output logic [7:0] int_flags,
  output logic [7:0] int_enables,
  output logic global_int_en
);
  timeunit 1ns;
  timeprecision 1ps;
  // a halted core fetches nothing, so no halt is issued while asleep
  always_ff @(posedge clk) begin
    halt_exec <= halt_go && !sleeping && !rst;
  end
  // sources present their flag and enable levels directly
  assign int_flags = src_flags;
  assign int_enables = src_en;
  assign global_int_en = global_interrupt_enable;
endmodule

// File: sim/tb_sleep_wakeup_control.sv
module tb_sleep_wakeup_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, srst, awvalid, wvalid, bready, arvalid, rready, halt_go, global_interrupt_enable;
  logic [7:0] awaddr, araddr, flags, en, int_flags, int_en;
  logic [31:0] wdata, rdata, rd_val, cnt0;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rd_resp;
  logic awready, wready, bvalid, arready, rvalid, halt_exec, gie_o;
  logic halt_nop, sleeping, wake, wdt_clear, prefetch, force_nop, vector, irq;
  int failures, total_checks;
  // ----------------------------------------
  // design and partner
  // ----------------------------------------
  swc_top swc_top_inst (.MCLK(mclk), .SRST(srst), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .INT_FLAGS(int_flags), .INT_ENABLES(int_en),
    .GLOBAL_INTERRUPT_ENABLE(gie_o), .HALT_EXEC(halt_exec), .HALT_NOP(halt_nop),
    .SLEEPING(sleeping), .WAKE(wake), .WDT_CLEAR(wdt_clear), .EXEC_PREFETCH(prefetch),
    .FORCE_NOP(force_nop), .VECTOR_BRANCH(vector), .IRQ(irq));
  swc_core_model swc_core_model_inst (.clk(mclk), .rst(srst), .halt_go(halt_go),
    .src_flags(flags), .src_en(en), .global_interrupt_enable(global_interrupt_enable), .sleeping(sleeping),
    .halt_exec(halt_exec), .int_flags(int_flags), .int_enables(int_en),
    .global_int_en(gie_o));
  // free-running clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic step();
    @(posedge mclk);
    #1;
  endtask
  task automatic hang(input int n, input int lim);
    if (n >= lim) begin
      failures++;
      end_of_test();
    end
  endtask
  // write one word, holding each channel until it is taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 50);
    bready <= 1'b0;
    hang(n, 50);
    chk("bresp", 32'(swc_pkg::RESP_OKAY), 32'(bresp));
  endtask
  task automatic axi_rd(input logic [7:0] a);
    int n;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 50);
    rd_val = rdata;
    rd_resp = rresp;
    rready <= 1'b0;
    hang(n, 50);
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    axi_rd(a);
    chk(what, exp, rd_val);
  endtask
  // halt request goes through the core model, answer lands one edge later
  task automatic halt();
    @(posedge mclk);
    halt_go <= 1'b1;
    @(posedge mclk);
    halt_go <= 1'b0;
    step();
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd_chk("status", swc_pkg::OFS_STATUS, 32'h3);
    rd_chk("mask", swc_pkg::OFS_INT_MASK, 32'h0);
    rd_chk("unmapped", 8'h20, 32'h0);
    chk("unmapped_resp", 32'(swc_pkg::RESP_SLVERR), 32'(rd_resp));
    $display("test reset done");
  endtask
  task automatic t_wdt_irq();
    int n;
    axi_wr(swc_pkg::OFS_INT_MASK, 32'h4);
    axi_wr(swc_pkg::OFS_CTRL, 32'h1);
    n = 0;
    while (irq !== 1'b1 && n < 10000) begin
      step();
      n++;
    end
    hang(n, 10000);
    chk("irq_wdt", 32'h1, 32'(irq));
    rd_chk("status_ovf", swc_pkg::OFS_STATUS, 32'h2);
    axi_wr(swc_pkg::OFS_INT_STAT, 32'h4);
    chk("irq_clr", 32'h0, 32'(irq));
    axi_wr(swc_pkg::OFS_INT_MASK, 32'h2);
    repeat (400) step();
    $display("test watchdog done");
  endtask
  task automatic t_halt_nop();
    axi_rd(swc_pkg::OFS_WDT_COUNT);
    cnt0 = rd_val;
    @(posedge mclk);
    global_interrupt_enable <= 1'b0;
    en <= 8'h08;
    flags <= 8'h08;
    halt();
    chk("halt_nop", 32'h1, 32'(halt_nop));
    chk("sleeping", 32'h0, 32'(sleeping));
    chk("wdt_clear", 32'h0, 32'(wdt_clear));
    rd_chk("status_nop", swc_pkg::OFS_STATUS, 32'h2);
    axi_rd(swc_pkg::OFS_WDT_COUNT);
    chk("wdt_kept", 32'h1, 32'(rd_val >= cnt0 && cnt0 != 32'h0));
    rd_chk("int_stat", swc_pkg::OFS_INT_STAT, 32'h1);
    chk("irq_masked", 32'h0, 32'(irq));
    axi_wr(swc_pkg::OFS_INT_STAT, 32'h1);
    @(posedge mclk);
    flags <= 8'h00;
    $display("test halt_nop done");
  endtask
  task automatic t_sleep_wake(input logic g, input int idx);
    @(posedge mclk);
    global_interrupt_enable <= g;
    en <= 8'h01 << idx;
    halt();
    chk("sleep", 32'h1, 32'(sleeping));
    chk("no_nop", 32'h0, 32'(halt_nop));
    repeat (3) step();
    @(posedge mclk);
    flags <= ~en;
    step();
    chk("other_src", 32'h1, 32'(sleeping));
    @(posedge mclk);
    flags <= en;
    step();
    chk("wake", 32'h1, 32'(wake));
    chk("awake", 32'h0, 32'(sleeping));
    chk("wdt_clear", 32'h1, 32'(wdt_clear));
    chk("prefetch", 32'(g), 32'(prefetch));
    step();
    chk("fnop1", 32'(g), 32'(force_nop));
    step();
    chk("fnop2", 32'(g), 32'(force_nop));
    step();
    chk("vector", 32'(g), 32'(vector));
    @(posedge mclk);
    flags <= 8'h00;
    rd_chk("status_wake", swc_pkg::OFS_STATUS, 32'h1);
    rd_chk("wdt_count", swc_pkg::OFS_WDT_COUNT, 32'h0);
    chk("irq_wake", 32'h1, 32'(irq));
    axi_wr(swc_pkg::OFS_INT_STAT, 32'h2);
    chk("irq_off", 32'h0, 32'(irq));
    axi_wr(swc_pkg::OFS_CTRL, 32'h3);
    rd_chk("status_rearm", swc_pkg::OFS_STATUS, 32'h3);
    $display("test sleep_wake gie %0d done", g);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    failures = 0;
    total_checks = 0;
    srst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, halt_go, global_interrupt_enable} = '0;
    {awaddr, araddr, flags, en, wdata, wstrb} = '0;
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    t_reset();
    t_wdt_irq();
    t_halt_nop();
    t_sleep_wake(1'b0, 0);
    t_sleep_wake(1'b1, 7);
    end_of_test();
  end
endmodule
